// File: rtl/sfr_bank_pkg.sv
package sfr_bank_pkg;

   // ==========================================================
   // bus geometry
   // ==========================================================
   localparam int ADDR_W = 10;            // byte address, four bytes per register index
   localparam int IDX_W = 8;              // register index width
   localparam int DATA_W = 32;            // avalon data width
   localparam int PC_W = 13;              // full program counter
   localparam int LATCH_W = 5;            // upper counter bits held by the latch
   localparam int JUMP_W = 11;            // target bits carried by a core jump
   localparam int MEM_DEPTH = 256;        // bytes reachable through the pointer

   // ==========================================================
   // register indices (byte address = index * 4)
   // ==========================================================
   localparam logic [7:0] IDX_INDIRECT = 8'h80;
   localparam logic [7:0] IDX_OPTION = 8'h81;
   localparam logic [7:0] IDX_PCL = 8'h82;
   localparam logic [7:0] IDX_STATUS = 8'h83;
   localparam logic [7:0] IDX_POINTER = 8'h84;
   localparam logic [7:0] IDX_PORT_A_DIRECTION = 8'h85;
   localparam logic [7:0] IDX_PORT_B_DIRECTION = 8'h86;
   localparam logic [7:0] IDX_PORT_C_DIRECTION = 8'h87;
   localparam logic [7:0] IDX_LATCH = 8'h8a;
   localparam logic [7:0] IDX_INTCTL = 8'h8b;
   localparam logic [7:0] IDX_PIE = 8'h8c;
   localparam logic [7:0] IDX_POWER_RESET_FLAGS = 8'h8e;
   localparam logic [7:0] IDX_PERIOD = 8'h92;
   localparam logic [7:0] IDX_SLAVE_ADDR = 8'h93;
   localparam logic [7:0] IDX_SERIAL_STATE = 8'h94;
   localparam logic [7:0] IDX_ANALOG_CFG = 8'h9f;
   localparam logic [7:0] BANK1_BIT = 8'h80;  // set on every second-bank index

   // ==========================================================
   // plain storage registers: index, writable mask, reset value
   // ==========================================================
   localparam int PLAIN_N = 8;
   localparam logic [7:0] PLAIN_IDX [PLAIN_N] = '{
      IDX_OPTION, IDX_PORT_A_DIRECTION, IDX_PORT_B_DIRECTION, IDX_PORT_C_DIRECTION,
      IDX_PIE, IDX_PERIOD, IDX_SLAVE_ADDR, IDX_ANALOG_CFG};
   localparam logic [7:0] PLAIN_MASK [PLAIN_N] = '{
      8'hff, 8'h3f, 8'hff, 8'hff, 8'h4f, 8'hff, 8'hff, 8'h07};
   localparam logic [7:0] PLAIN_RST [PLAIN_N] = '{
      8'hff, 8'h3f, 8'hff, 8'hff, 8'h00, 8'hff, 8'h00, 8'h00};

   // ==========================================================
   // core registers: masks and reset values
   // ==========================================================
   localparam logic [7:0] STATUS_RST = 8'h18;       // power-up: timeout and powerdown set
   localparam logic [7:0] STATUS_SW_MASK = 8'he7;   // timeout/powerdown not writable
   localparam logic [7:0] STATUS_WARM_KEEP = 8'h07; // arithmetic flags survive warm reset
   localparam int STATUS_TO_BIT = 4;
   localparam int STATUS_PD_BIT = 3;
   localparam int STATUS_IBS_BIT = 7;
   localparam int STATUS_DBH_BIT = 6;
   localparam int STATUS_RP0_BIT = 5;
   localparam logic [7:0] POINTER_RST = 8'h00;
   localparam logic [7:0] INTCTL_RST = 8'h00;
   localparam logic [7:0] INTCTL_WARM_KEEP = 8'h01; // only the port-change flag survives
   localparam logic [7:0] POWER_RESET_FLAGS_MASK = 8'h03;
   localparam logic [7:0] POWER_RESET_FLAGS_RST = 8'h00;
   localparam logic [4:0] LATCH_RST = 5'h00;
   localparam logic [12:0] PC_RST = 13'h0000;
   localparam logic [5:0] SERIAL_MASK = 6'h3f;

   // ==========================================================
   // decoded target of an access
   // ==========================================================
   typedef enum logic [3:0] {
      SEL_NONE = 4'b0000,
      SEL_INDIRECT = 4'b0001,
      SEL_PCL = 4'b0010,
      SEL_STATUS = 4'b0011,
      SEL_POINTER = 4'b0100,
      SEL_LATCH = 4'b0101,
      SEL_INTCTL = 4'b0110,
      SEL_POWER_RESET_FLAGS = 4'b0111,
      SEL_SERIAL = 4'b1000,
      SEL_PLAIN = 4'b1001
   } sel_t;

endpackage

// File: rtl/data_memory.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// byte memory behind the indirect access port
// ==========================================================
module data_memory
   import sfr_bank_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_ce,
   input wire logic i_we,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rdata
);
   // contents are not cleared by any reset, like real ram
   logic [7:0] mem [MEM_DEPTH];

   // write port, frozen with the clock enable
   always_ff @(posedge i_clk) begin
      if (i_ce && i_we) begin
         mem[i_addr] <= i_wdata;
      end
   end

   // read is asynchronous so the bus can sample it on the same cycle
   assign o_rdata = mem[i_addr];

endmodule
`default_nettype wire

// File: rtl/special_register_bank.sv
`timescale 1ns/1ps
`default_nettype none

// Operation
// - core registers mirrored at both bank addresses, except power reset flags
// - no address reaches upper program counter
// - latch holds pc 12:8, copied on update
// - external or watchdog reset uses warm values
module special_register_bank
   import sfr_bank_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   input wire logic [sfr_bank_pkg::ADDR_W-1:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [sfr_bank_pkg::DATA_W-1:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [sfr_bank_pkg::DATA_W-1:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic i_warm_rst,
   input wire logic i_warm_timeout,
   input wire logic i_warm_powerdown,
   input wire logic i_pc_advance,
   input wire logic i_pc_jump,
   input wire logic [sfr_bank_pkg::JUMP_W-1:0] i_pc_jump_target,
   input wire logic [5:0] i_serial_state,
   output logic [sfr_bank_pkg::PC_W-1:0] o_pc,
   output logic o_indirect_bank_select,
   output logic o_direct_bank_select_high,
   output logic o_bank_select_low,
   output logic [7:0] o_interrupt_control,
   output logic [7:0] o_option_config,
   output logic [7:0] o_port_a_direction,
   output logic [7:0] o_port_b_direction,
   output logic [7:0] o_port_c_direction,
   output logic [7:0] o_peripheral_irq_enable,
   output logic [7:0] o_timer_period,
   output logic [7:0] o_serial_slave_address,
   output logic [7:0] o_analog_pin_config
);
   import sfr_bank_pkg::*;

   // ==========================================================
   // decode helpers
   // ==========================================================
   // bank-zero aliases fold onto the second-bank index
   function automatic sel_t decode_sel(input logic [7:0] idx);
      logic [7:0] f;
      sel_t s;
      f = idx | BANK1_BIT;
      s = SEL_NONE;
      if (idx == IDX_INDIRECT || f == IDX_INDIRECT) s = SEL_INDIRECT;
      else if (idx == IDX_PCL || f == IDX_PCL) s = SEL_PCL;
      else if (idx == IDX_STATUS || f == IDX_STATUS) s = SEL_STATUS;
      else if (idx == IDX_POINTER || f == IDX_POINTER) s = SEL_POINTER;
      else if (idx == IDX_LATCH || f == IDX_LATCH) s = SEL_LATCH;
      else if (idx == IDX_INTCTL || f == IDX_INTCTL) s = SEL_INTCTL;
      else if (idx == IDX_POWER_RESET_FLAGS) s = SEL_POWER_RESET_FLAGS;
      else if (idx == IDX_SERIAL_STATE) s = SEL_SERIAL;
      else begin
         for (int k = 0; k < PLAIN_N; k++) begin
            if (idx == PLAIN_IDX[k]) s = SEL_PLAIN;
         end
      end
      return s;
   endfunction

   // ==========================================================
   // avalon slave handshake
   // ==========================================================
   logic [7:0] idx;           // register index from the byte address
   sel_t sel;                 // decoded target
   logic req;                 // read or write pending
   logic ack_q;               // second cycle of a request
   logic accept;              // edge at which the request completes
   logic wr_ok;               // accepted write on the low byte lane
   logic [7:0] wbyte;         // low byte of the write data

   assign idx = i_avs_address[ADDR_W-1:2];
   assign sel = decode_sel(idx);
   assign req = i_avs_read | i_avs_write;
   // one wait state on every access; clock enable low stretches it
   assign o_avs_waitrequest = req & ~(ack_q & i_ce);
   assign accept = req & ack_q & i_ce;
   assign wr_ok = accept & i_avs_write & i_avs_byteenable[0];
   assign wbyte = i_avs_writedata[7:0];

   // ack toggles high for one enabled cycle per request
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ack_q <= 1'b0;
      end else if (i_ce) begin
         ack_q <= req & ~ack_q;
      end
   end

   // ==========================================================
   // plain storage registers
   // ==========================================================
   logic [7:0] plain_q [PLAIN_N];   // same value on every reset class

   generate
      for (genvar g = 0; g < PLAIN_N; g++) begin : g_plain
         // reserved bits stay zero through the mask
         always_ff @(posedge i_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
               plain_q[g] <= PLAIN_RST[g];
            end else if (i_ce) begin
               if (i_warm_rst) begin
                  plain_q[g] <= PLAIN_RST[g];
               end else if (wr_ok && idx == PLAIN_IDX[g]) begin
                  plain_q[g] <= wbyte & PLAIN_MASK[g];
               end
            end
         end
      end
   endgenerate

   // ==========================================================
   // core registers shared by both banks, except the power reset flags
   // ==========================================================
   logic [7:0] status_q;     // bank selects, reset cause, arithmetic flags
   logic [7:0] pointer_q;    // indirect pointer
   logic [7:0] intctl_q;     // interrupt control
   logic [7:0] power_reset_flags_q;       // power reset flags
   logic [4:0] latch_q;      // write buffer for pc 12:8

   // status: warm reset loads the cause bits from the core
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         status_q <= STATUS_RST;
      end else if (i_ce) begin
         if (i_warm_rst) begin
            status_q <= status_q & STATUS_WARM_KEEP;
            status_q[STATUS_TO_BIT] <= i_warm_timeout;
            status_q[STATUS_PD_BIT] <= i_warm_powerdown;
         end else if (wr_ok && sel == SEL_STATUS) begin
            // reserved bank bits are stored as written; software keeps them clear
            status_q <= (status_q & ~STATUS_SW_MASK) | (wbyte & STATUS_SW_MASK);
         end
      end
   end

   // pointer keeps its value on a warm reset
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pointer_q <= POINTER_RST;
      end else if (i_ce && !i_warm_rst && wr_ok && sel == SEL_POINTER) begin
         pointer_q <= wbyte;
      end
   end

   // interrupt control: all but the port-change flag clear on warm reset
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         intctl_q <= INTCTL_RST;
      end else if (i_ce) begin
         if (i_warm_rst) begin
            intctl_q <= intctl_q & INTCTL_WARM_KEEP;
         end else if (wr_ok && sel == SEL_INTCTL) begin
            intctl_q <= wbyte;
         end
      end
   end

   // power flags are untouched by warm resets
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         power_reset_flags_q <= POWER_RESET_FLAGS_RST;
      end else if (i_ce && !i_warm_rst && wr_ok && sel == SEL_POWER_RESET_FLAGS) begin
         power_reset_flags_q <= wbyte & POWER_RESET_FLAGS_MASK;
      end
   end

   // latch: a write only buffers, it never moves the counter
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         latch_q <= LATCH_RST;
      end else if (i_ce) begin
         if (i_warm_rst) begin
            latch_q <= LATCH_RST;
         end else if (wr_ok && sel == SEL_LATCH) begin
            latch_q <= wbyte[LATCH_W-1:0];
         end
      end
   end

   // ==========================================================
   // program counter
   // ==========================================================
   logic [12:0] pc_q;
   logic pcl_wr;

   assign pcl_wr = wr_ok & (sel == SEL_PCL);

   // the upper byte has no address; it only moves by counting, reset, jump target bits 10:8 or from the latch
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pc_q <= PC_RST;
      end else if (i_ce) begin
         if (i_warm_rst) begin
            pc_q <= PC_RST;
         end else if (pcl_wr) begin
            pc_q <= {latch_q, wbyte};
         end else if (i_pc_jump) begin
            // jump carries 11 bits; the top two come from the latch
            pc_q <= {latch_q[4:3], i_pc_jump_target};
         end else if (i_pc_advance) begin
            pc_q <= pc_q + 13'h0001;
         end
      end
   end

   // ==========================================================
   // indirect access through the pointer
   // ==========================================================
   logic [7:0] mem_rdata;

   // no storage of its own: reads and writes land in the ram
   data_memory u_mem (
      .i_clk(i_clk),
      .i_ce(i_ce),
      .i_we(wr_ok & (sel == SEL_INDIRECT) & ~i_warm_rst),
      .i_addr(pointer_q),
      .i_wdata(wbyte),
      .o_rdata(mem_rdata)
   );

   // ==========================================================
   // read data
   // ==========================================================
   logic [7:0] rbyte;
   logic [31:0] rdata_q;

   // read mux; unmapped and upper-counter indices answer zero
   always_comb begin
      rbyte = 8'h00;
      unique case (sel)
         SEL_INDIRECT: rbyte = mem_rdata;
         SEL_PCL: rbyte = pc_q[7:0];
         SEL_STATUS: rbyte = status_q;
         SEL_POINTER: rbyte = pointer_q;
         SEL_LATCH: rbyte = {3'h0, latch_q};
         SEL_INTCTL: rbyte = intctl_q;
         SEL_POWER_RESET_FLAGS: rbyte = power_reset_flags_q;
         SEL_SERIAL: rbyte = {2'h0, i_serial_state & SERIAL_MASK};
         SEL_PLAIN: begin
            for (int k = 0; k < PLAIN_N; k++) begin
               if (idx == PLAIN_IDX[k]) rbyte = plain_q[k];
            end
         end
         SEL_NONE: rbyte = 8'h00;
         default: rbyte = 8'h00;
      endcase
   end

   // captured in the wait cycle, stands through the accept edge
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rdata_q <= 32'h0000_0000;
      end else if (i_ce && i_avs_read && !ack_q) begin
         rdata_q <= {24'h00_0000, rbyte};
      end
   end

   // ==========================================================
   // outputs
   // ==========================================================
   assign o_avs_readdata = rdata_q;
   assign o_pc = pc_q;
   assign o_indirect_bank_select = status_q[STATUS_IBS_BIT];
   assign o_direct_bank_select_high = status_q[STATUS_DBH_BIT];
   assign o_bank_select_low = status_q[STATUS_RP0_BIT];
   assign o_interrupt_control = intctl_q;
   assign o_option_config = plain_q[0];
   assign o_port_a_direction = plain_q[1];
   assign o_port_b_direction = plain_q[2];
   assign o_port_c_direction = plain_q[3];
   assign o_peripheral_irq_enable = plain_q[4];
   assign o_timer_period = plain_q[5];
   assign o_serial_slave_address = plain_q[6];
   assign o_analog_pin_config = plain_q[7];

   // ==========================================================
   // checks
   // ==========================================================
   sequence bus_wait_s;
      req && !ack_q;
   endsequence

   sequence bus_accept_s;
      accept;
   endsequence

   wait_answer_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (bus_wait_s and i_ce) |=> (!o_avs_waitrequest || !i_ce || !req))
      else $error("request not answered after one wait cycle");

   mirror_pointer_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (bus_accept_s and (i_avs_write && i_avs_byteenable[0] && !i_warm_rst
       && (idx == (IDX_POINTER & ~BANK1_BIT) || idx == IDX_POINTER)))
      |=> pointer_q == $past(wbyte))
      else $error("pointer write at either bank alias lost");

   pc_upper_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (!pcl_wr && !i_pc_jump && !i_pc_advance && !i_warm_rst)
      |=> pc_q[12:8] == $past(pc_q[12:8]))
      else $error("upper counter moved without an update");

   latch_copy_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (pcl_wr && !i_warm_rst) |=> pc_q == {$past(latch_q), $past(wbyte)})
      else $error("latch not copied on counter low write");

   warm_values_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_warm_rst && i_ce) |=> (status_q[7:5] == 3'h0 && plain_q[0] == PLAIN_RST[0]
       && pointer_q == $past(pointer_q) && intctl_q[7:1] == 7'h00
       && status_q[STATUS_TO_BIT] == $past(i_warm_timeout)))
      else $error("warm reset values wrong");

   indirect_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (bus_wait_s and (i_ce && i_avs_read && sel == SEL_INDIRECT && !i_warm_rst))
      ##1 (bus_accept_s and i_avs_read) |-> o_avs_readdata[7:0] == mem_rdata)
      else $error("indirect read not from pointed memory");

endmodule
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   import sfr_bank_pkg::*;

   // ==========================================================
   // stimulus and observed signals
   // ==========================================================
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;               // held low for the first 20 cycles
   logic i_ce = 1'b1;
   logic [ADDR_W-1:0] i_avs_address = '0;
   logic i_avs_read = 1'b0;
   logic i_avs_write = 1'b0;
   logic [DATA_W-1:0] i_avs_writedata = '0;
   logic [3:0] i_avs_byteenable = 4'h1;
   logic i_warm_rst = 1'b0;
   logic i_warm_timeout = 1'b0;
   logic i_warm_powerdown = 1'b0;
   logic i_pc_advance = 1'b0;
   logic i_pc_jump = 1'b0;
   logic [JUMP_W-1:0] i_pc_jump_target = '0;
   logic [5:0] i_serial_state = 6'h00;
   logic [DATA_W-1:0] o_avs_readdata;
   logic o_avs_waitrequest;
   logic [PC_W-1:0] o_pc;
   logic o_indirect_bank_select, o_direct_bank_select_high, o_bank_select_low;
   logic [7:0] o_interrupt_control, o_option_config, o_port_a_direction;
   logic [7:0] o_port_b_direction, o_port_c_direction, o_peripheral_irq_enable;
   logic [7:0] o_timer_period, o_serial_slave_address, o_analog_pin_config;
   int mismatches = 0;                 // wrong values plus timeouts
   int tests_run = 0;                  // every comparison made
   logic [31:0] rd;                    // last read result
   logic [PC_W-1:0] pc_keep;           // counter snapshot
   logic [7:0] pv [8];                 // plain register outputs by slot
   // bank-zero alias, bank-one twin, written value, expected readback
   logic [7:0] al_lo [5] = '{8'h04, 8'h0a, 8'h0b, 8'h03, 8'h02};
   logic [7:0] al_v [5] = '{8'h3c, 8'h13, 8'hc2, 8'h05, 8'h77};
   logic [7:0] al_e [5] = '{8'h3c, 8'h13, 8'hc2, 8'h1d, 8'h77};
   // second readback: latch keeps five bits, status keeps its cause bits
   logic [7:0] al_f [5] = '{8'h03, 8'h0c, 8'h3d, 8'h3a, 8'h08};
   logic [7:0] pl_rst [8] = '{8'hff, 8'h3f, 8'hff, 8'hff, 8'h00, 8'hff, 8'h00, 8'h00};

   always #12.5 i_clk = ~i_clk;        // 40 mhz

   assign pv = '{o_option_config, o_port_a_direction, o_port_b_direction,
      o_port_c_direction, o_peripheral_irq_enable, o_timer_period,
      o_serial_slave_address, o_analog_pin_config};

   special_register_bank i_special_register_bank (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
      .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
      .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
      .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
      .o_avs_waitrequest(o_avs_waitrequest), .i_warm_rst(i_warm_rst),
      .i_warm_timeout(i_warm_timeout), .i_warm_powerdown(i_warm_powerdown),
      .i_pc_advance(i_pc_advance), .i_pc_jump(i_pc_jump),
      .i_pc_jump_target(i_pc_jump_target), .i_serial_state(i_serial_state),
      .o_pc(o_pc), .o_indirect_bank_select(o_indirect_bank_select),
      .o_direct_bank_select_high(o_direct_bank_select_high),
      .o_bank_select_low(o_bank_select_low), .o_interrupt_control(o_interrupt_control),
      .o_option_config(o_option_config), .o_port_a_direction(o_port_a_direction),
      .o_port_b_direction(o_port_b_direction), .o_port_c_direction(o_port_c_direction),
      .o_peripheral_irq_enable(o_peripheral_irq_enable), .o_timer_period(o_timer_period),
      .o_serial_slave_address(o_serial_slave_address),
      .o_analog_pin_config(o_analog_pin_config)
   );

   // ==========================================================
   // reporting
   // ==========================================================
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask

   // ==========================================================
   // avalon master: request after an edge, held until waitrequest low
   // ==========================================================
   task automatic bus_xfer(input logic wr, input logic [7:0] idx, input logic [7:0] d);
      @(posedge i_clk);
      i_avs_address <= {idx, 2'b00};
      i_avs_writedata <= {24'h000000, d};
      i_avs_write <= wr;
      i_avs_read <= ~wr;
      // waitrequest as it stands at each rising edge; only the watchdog ends a hang
      do begin
         @(posedge i_clk);
      end while (o_avs_waitrequest !== 1'b0);
      rd = o_avs_readdata;             // read data stands at the accept edge
      i_avs_write <= 1'b0;
      i_avs_read <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      bus_xfer(1'b1, idx, d);
   endtask

   task automatic rd_chk(input string name, input logic [7:0] idx, input logic [7:0] e);
      bus_xfer(1'b0, idx, 8'h00);
      check(name, {24'h000000, e}, rd);
   endtask

   function automatic bit mapped(input logic [7:0] i);
      return i inside {8'h00, 8'h02, 8'h03, 8'h04, 8'h0a, 8'h0b, 8'h80, 8'h82, 8'h83,
         8'h84, 8'h8a, 8'h8b, 8'h8e, 8'h94} || i inside {PLAIN_IDX};
   endfunction

   // ==========================================================
   // watchdog: the whole sequence needs well under 10000 cycles
   // ==========================================================
   initial begin
      repeat (20000) @(posedge i_clk);
      mismatches++;
      close_out();
   end

   // ==========================================================
   // main sequence
   // ==========================================================
   initial begin
      repeat (20) @(posedge i_clk);
      i_rst_n <= 1'b1;
      // power-up values of the core registers other than the pointer, and of the plain registers
      rd_chk("status", 8'h83, 8'h18);
      rd_chk("pcl", 8'h82, 8'h00);
      rd_chk("latch", 8'h8a, 8'h00);
      rd_chk("intctl", 8'h8b, 8'h00);
      rd_chk("power_reset_flags", 8'h8e, 8'h00);
      for (int i = 0; i < PLAIN_N; i++) begin
         rd_chk("plain reset", PLAIN_IDX[i], pl_rst[i]);
         wr(PLAIN_IDX[i], 8'ha5);
         rd_chk("plain rw", PLAIN_IDX[i], 8'ha5 & PLAIN_MASK[i]);
         check("plain out", {24'h0, 8'ha5 & PLAIN_MASK[i]}, {24'h0, pv[i]});
      end
      // both bank addresses reach one register
      for (int i = 0; i < 5; i++) begin
         wr(al_lo[i], al_v[i]);
         rd_chk("alias hi", al_lo[i] | BANK1_BIT, al_e[i]);
         wr(al_lo[i] | BANK1_BIT, ~al_v[i] & 8'h3f);
         rd_chk("alias lo", al_lo[i], al_f[i]);
      end
      // indirect port follows the pointer, no storage of its own
      wr(8'h84, 8'h5a);
      wr(8'h80, 8'ha5);
      wr(8'h84, 8'h5b);
      wr(8'h00, 8'h3c);
      rd_chk("indirect", 8'h80, 8'h3c);
      wr(8'h84, 8'h5a);
      rd_chk("indirect", 8'h00, 8'ha5);
      // latch is five bits and moves the counter only on update
      wr(8'h8a, 8'hff);
      rd_chk("latch", 8'h8a, 8'h1f);
      pc_keep = o_pc;
      wr(8'h8a, 8'h0b);
      @(negedge i_clk);                // counter settles after the accept edge
      check("pc held", {19'h0, pc_keep}, {19'h0, o_pc});
      wr(8'h82, 8'h34);
      @(negedge i_clk);
      check("pc load", {19'h0, 13'h0b34}, {19'h0, o_pc});
      @(posedge i_clk);
      i_pc_jump_target <= 11'h5e7;
      i_pc_jump <= 1'b1;
      @(posedge i_clk);
      i_pc_jump <= 1'b0;
      i_pc_advance <= 1'b1;
      repeat (3) @(posedge i_clk);
      i_pc_advance <= 1'b0;
      @(negedge i_clk);
      check("pc jump", {19'h0, 2'b01, 11'h5ea}, {19'h0, o_pc});
      // unmapped indices read zero and never reach the upper counter
      pc_keep = o_pc;
      for (int i = 0; i < 256; i++) begin
         if (!mapped(i[7:0])) begin
            wr(i[7:0], 8'hff);
            rd_chk("unmapped", i[7:0], 8'h00);
         end
      end
      check("pc upper", {19'h0, pc_keep}, {19'h0, o_pc});
      rd_chk("latch", 8'h8a, 8'h0b);
      // serial state is read only; lane enable off stores nothing
      i_serial_state <= 6'h2a;
      wr(8'h94, 8'hff);
      rd_chk("serial", 8'h94, 8'h2a);
      i_avs_byteenable <= 4'h0;
      wr(8'h81, 8'h00);
      i_avs_byteenable <= 4'h1;
      rd_chk("byteenable", 8'h81, 8'ha5);
      // clock enable low stretches the wait
      fork
         wr(8'h92, 8'h66);
         begin
            @(posedge i_clk);
            i_ce <= 1'b0;
            repeat (3) @(posedge i_clk);
            i_ce <= 1'b1;
         end
      join
      rd_chk("ce stall", 8'h92, 8'h66);
      // warm reset: other-reset values, not power-up ones
      wr(8'h83, 8'h27);
      @(negedge i_clk);
      check("bank select", 32'h1, {29'h0, o_indirect_bank_select, o_direct_bank_select_high, o_bank_select_low});
      wr(8'h8b, 8'hff);
      wr(8'h84, 8'h44);
      wr(8'h8e, 8'h03);
      wr(8'h8a, 8'h1f);
      i_warm_timeout <= 1'b1;
      i_warm_powerdown <= 1'b0;
      i_warm_rst <= 1'b1;
      @(posedge i_clk);
      i_warm_rst <= 1'b0;
      rd_chk("warm status", 8'h83, 8'h17);
      rd_chk("warm intctl", 8'h8b, 8'h01);
      rd_chk("warm pointer", 8'h84, 8'h44);
      rd_chk("warm power_reset_flags", 8'h8e, 8'h03);
      rd_chk("warm latch", 8'h8a, 8'h00);
      rd_chk("warm period", 8'h92, 8'hff);
      check("warm pc", 32'h0, {19'h0, o_pc});
      check("warm rp0", 32'h0, {31'h0, o_bank_select_low});
      check("warm intctl out", 32'h1, {24'h0, o_interrupt_control});
      close_out();
   end

endmodule

`default_nettype wire
